// ### hw/scg_glue_regs.sv
`timescale 1ns/10ps
module scg_glue_regs #(
  parameter logic ALT_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Host I/O port
  input  wire scg_pkg::scg_host_req_type host_req,
  output logic      [7:0]                host_rdata,
  output logic                           host_rvalid,
  output logic                           host_irq_b,
  // Auxiliary pins
  input  wire logic [7:0]                aux_pin_in,
  output logic      [7:0]                aux_pin_out,
  output logic      [7:0]                aux_pin_oe_b,
  // First UART
  output scg_pkg::scg_uart_req_type      uart0_req,
  input  wire logic [7:0]                uart0_rdata,
  input  wire logic                      uart0_irq,
  output logic                           uart0_speed_high,
  // Second UART
  output scg_pkg::scg_uart_req_type      uart1_req,
  input  wire logic [7:0]                uart1_rdata,
  input  wire logic                      uart1_irq,
  output logic                           uart1_speed_high,
  // Card state
  output logic                           io_enabled
);
  import scg_pkg::*;

  //--------------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  wire logic wr = host_req.wr;
  wire logic rd = host_req.rd;

  wire logic wr_io_reset = wr & hit(host_req.addr, SCG_OFF_IO_RESET);
  wire logic wr_aux_dir  = wr & hit(host_req.addr, SCG_OFF_AUX_DIR);
  wire logic wr_aux_data = wr & hit(host_req.addr, SCG_OFF_AUX_DATA);
  wire logic wr_irq_en   = wr & hit(host_req.addr, SCG_OFF_IRQ_EN);
  wire logic wr_irq_pol  = wr & hit(host_req.addr, SCG_OFF_IRQ_POL);
  wire logic wr_p0_speed = wr & hit(host_req.addr, SCG_OFF_P0_SPEED);
  wire logic wr_p1_speed = wr & hit(host_req.addr, SCG_OFF_P1_SPEED);
  wire logic rd_status   = rd & hit(host_req.addr, SCG_OFF_AUX_STAT);
  wire logic p0_sel      = hit(host_req.addr, SCG_OFF_P0_DATA);
  wire logic p1_sel      = hit(host_req.addr, SCG_OFF_P1_DATA);

  //--------------------------------------------------------------------
  // Register state
  //--------------------------------------------------------------------
  logic       io_en_r;
  logic [7:0] aux_dir_r;
  logic [7:0] aux_data_r;
  logic [3:0] irq_en_r;
  logic [3:0] irq_pol_r;
  logic       p0_speed_r;
  logic       p1_speed_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_en_r    <= 1'b0;
      aux_dir_r  <= SCG_RST_AUX_DIR;
      aux_data_r <= SCG_RST_AUX_DATA;
      irq_en_r   <= SCG_RST_IRQ_EN;
      irq_pol_r  <= SCG_RST_IRQ_POL;
      p0_speed_r <= 1'b0;
      p1_speed_r <= 1'b0;
    end else begin
      if (wr_io_reset) io_en_r    <= host_req.wdata[SCG_IO_EN_BIT];
      if (wr_aux_dir)  aux_dir_r  <= host_req.wdata;
      if (wr_aux_data) aux_data_r <= host_req.wdata;
      if (wr_irq_en)   irq_en_r   <= host_req.wdata[3:0];
      if (wr_irq_pol)  irq_pol_r  <= host_req.wdata[3:0];
      if (wr_p0_speed) p0_speed_r <= host_req.wdata[SCG_SPEED_BIT];
      if (wr_p1_speed) p1_speed_r <= host_req.wdata[SCG_SPEED_BIT];
    end
  end

  //--------------------------------------------------------------------
  // Auxiliary pins
  //--------------------------------------------------------------------
  // Pins float while the card is disabled, whatever the direction says
  logic [7:0] aux_oe_b_r;
  logic [7:0] aux_oe_b_nxt;
  logic [7:0] aux_out_r;
  logic [7:0] aux_sync;

  assign aux_oe_b_nxt = ~(aux_dir_r & {8{io_en_r}});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_oe_b_r <= 8'hFF;
      aux_out_r  <= 8'h00;
    end else begin
      aux_oe_b_r <= aux_oe_b_nxt;
      aux_out_r  <= aux_data_r;
    end
  end

  assign aux_pin_oe_b = aux_oe_b_r;
  assign aux_pin_out  = aux_out_r;

  scg_sync2 u_aux_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (aux_pin_in),
    .sync_out (aux_sync)
  );

  //--------------------------------------------------------------------
  // Interrupt channels
  //--------------------------------------------------------------------
  logic [3:0] chan_irq_line;
  logic       irq_req;
  logic       host_irq_b_r;

  scg_irq_chan #(
    .ALT_VARIANT (ALT_VARIANT)
  ) u_irq_chan (
    .uart_irq          ({uart1_irq, uart0_irq}),
    .chan_irq_enable   (irq_en_r),
    .chan_irq_polarity (irq_pol_r),
    .chan_irq_line     (chan_irq_line),
    .irq_req           (irq_req)
  );

  // Level output: stays low as long as the card is enabled and any enabled channel is active
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_irq_b_r <= 1'b1;
    end else begin
      host_irq_b_r <= ~(irq_req & io_en_r);
    end
  end

  assign host_irq_b = host_irq_b_r;

  //--------------------------------------------------------------------
  // UART access
  //--------------------------------------------------------------------
  // UART strobes are withheld while the card is disabled
  // One driver per carrier: a packed struct must not be split between assigns
  wire logic p0_wr = wr & p0_sel & io_en_r;
  wire logic p0_rd = rd & p0_sel & io_en_r;
  wire logic p1_wr = wr & p1_sel & io_en_r;
  wire logic p1_rd = rd & p1_sel & io_en_r;

  assign uart0_req = '{wr: p0_wr, rd: p0_rd, wdata: host_req.wdata};
  assign uart1_req = '{wr: p1_wr, rd: p1_rd, wdata: host_req.wdata};

  assign uart0_speed_high = p0_speed_r;
  assign uart1_speed_high = p1_speed_r;

  //--------------------------------------------------------------------
  // Read return
  //--------------------------------------------------------------------
  // Interrupt positions show channel lines; the rest show the pins
  logic [7:0] chan_mask;
  logic [7:0] status_val;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       rvalid_r;

  assign chan_mask  = ALT_VARIANT ? 8'h0C : 8'h03;
  assign status_val = (aux_sync & ~chan_mask) | ({4'h0, chan_irq_line} & chan_mask);

  assign rdata_nxt = rd_status       ? status_val  :
                     uart0_req.rd    ? uart0_rdata :
                     uart1_req.rd    ? uart1_rdata :
                                       SCG_RD_NONE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd;
      if (rd) rdata_r <= rdata_nxt;
    end
  end

  assign host_rdata  = rdata_r;
  assign host_rvalid = rvalid_r;
  assign io_enabled  = io_en_r;

endmodule : scg_glue_regs

// ### hw/scg_pkg.sv
//----------------------------------------------------------------------
// Function
//----------------------------------------------------------------------
// Function
// - Decode offsets 0,2,3,5,0x2A as write registers, offset 7 as read status.
// - Board I/O enable bit 0 resets low; while low all card I/O is disabled; the code still answers status reads at offset 7 with the pins.
// - Direction bit n set makes aux pin n an output, clear an input.
// - All direction bits reset low so every aux pin starts as input.
// - Aux data register drives output pins; 0x80 lights LED on pin 7.
// - Enable register holds bits 3..0, upper zero; 0 blocks, 1 passes.
// - Two-port variant uses bits 0,1 per channel; alternate variant bits 2,3.
// - Status read returns channel lines on bits 0,1 or 2,3 by variant.
// - Polarity register bits 3..0, upper zero; 0 inverted, 1 non-inverted.
// - Offset 0xC0 reaches first UART data, 0xE0 the second UART data.
// - Offsets 0xDC and 0xFC select baud clock speed for each port.
// - Writing 2 selects 14.7456 MHz clock; 0, the default, 1.8432 MHz.
// - Channel line 0 comes from first UART, line 1 from second UART.
// - Host interrupt output is a level, active low, held while pending.
package scg_pkg;

  //--------------------------------------------------------------------
  // Register offsets
  //--------------------------------------------------------------------
  localparam logic [7:0] SCG_OFF_IO_RESET  = 8'h00;
  localparam logic [7:0] SCG_OFF_AUX_DIR   = 8'h02;
  localparam logic [7:0] SCG_OFF_AUX_DATA  = 8'h03;
  localparam logic [7:0] SCG_OFF_IRQ_EN    = 8'h05;
  localparam logic [7:0] SCG_OFF_AUX_STAT  = 8'h07;
  localparam logic [7:0] SCG_OFF_IRQ_POL   = 8'h2A;
  localparam logic [7:0] SCG_OFF_P0_DATA   = 8'hC0;
  localparam logic [7:0] SCG_OFF_P0_SPEED  = 8'hDC;
  localparam logic [7:0] SCG_OFF_P1_DATA   = 8'hE0;
  localparam logic [7:0] SCG_OFF_P1_SPEED  = 8'hFC;

  //--------------------------------------------------------------------
  // Field positions and widths
  //--------------------------------------------------------------------
  localparam int         SCG_IO_EN_BIT     = 0;
  localparam int         SCG_SPEED_BIT     = 1;
  localparam int         SCG_CHAN_BITS     = 4;
  localparam int         SCG_NUM_CHAN      = 2;
  localparam int         SCG_CH0_BASE_STD  = 0;
  localparam int         SCG_CH0_BASE_ALT  = 2;

  //--------------------------------------------------------------------
  // Reset values
  //--------------------------------------------------------------------
  localparam logic [7:0] SCG_RST_AUX_DIR   = 8'h00;
  localparam logic [7:0] SCG_RST_AUX_DATA  = 8'h00;
  localparam logic [3:0] SCG_RST_IRQ_EN    = 4'h0;
  localparam logic [3:0] SCG_RST_IRQ_POL   = 4'h0;
  localparam logic [7:0] SCG_RD_NONE       = 8'h00;

  //--------------------------------------------------------------------
  // Carriers
  //--------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scg_host_req_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } scg_uart_req_type;

endpackage : scg_pkg

// ### hw/scg_sync2.sv
`timescale 1ns/10ps
module scg_sync2 (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Data
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);
  import scg_pkg::*;

  logic [7:0] meta_r;
  logic [7:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : scg_sync2

// ### hw/scg_irq_chan.sv
`timescale 1ns/10ps
module scg_irq_chan #(
  parameter logic ALT_VARIANT = 1'b0
) (
  // Sources
  input  wire logic [1:0] uart_irq,
  // Control
  input  wire logic [3:0] chan_irq_enable,
  input  wire logic [3:0] chan_irq_polarity,
  // Results
  output logic      [3:0] chan_irq_line,
  output logic            irq_req
);
  import scg_pkg::*;

  localparam int CH0 = ALT_VARIANT ? SCG_CH0_BASE_ALT : SCG_CH0_BASE_STD;

  logic [3:0] enabled;

  // Unused positions of the other variant stay low
  always_comb begin
    chan_irq_line = 4'h0;
    enabled       = 4'h0;
    for (int i = 0; i < SCG_NUM_CHAN; i++) begin
      chan_irq_line[CH0+i] = chan_irq_polarity[CH0+i] ? uart_irq[i]
                                                      : ~uart_irq[i];
      enabled[CH0+i] = chan_irq_line[CH0+i] & chan_irq_enable[CH0+i];
    end
  end

  assign irq_req = |enabled;

endmodule : scg_irq_chan

// ### dv/scg_uart_model.sv
`timescale 1ns/10ps
module scg_uart_model (
  // Clock
  input  wire logic                      clk,
  // Glue side
  input  wire scg_pkg::scg_uart_req_type req,
  input  wire logic                      irq_set,
  output logic      [7:0]                rdata,
  output logic                           irq
);
  import scg_pkg::*;
  logic [7:0] data_r;
  // Outside a read the bus shows the inverse, so a stale value never matches
  assign rdata = req.rd ? data_r : ~data_r;
  assign irq   = irq_set;
  always_ff @(posedge clk) begin
    if (req.wr) data_r <= req.wdata;
  end
endmodule : scg_uart_model

// ### dv/scg_glue_regs_checker.sv
`timescale 1ns/10ps
module scg_glue_regs_checker (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Observed ports
  input  wire scg_pkg::scg_host_req_type host_req,
  input  wire logic      [7:0]           host_rdata,
  input  wire logic                      host_rvalid,
  input  wire logic                      host_irq_b,
  input  wire logic      [7:0]           aux_pin_oe_b,
  input  wire scg_pkg::scg_uart_req_type uart0_req,
  input  wire logic      [7:0]           uart0_rdata,
  input  wire scg_pkg::scg_uart_req_type uart1_req,
  input  wire logic                      uart0_speed_high,
  input  wire logic                      io_enabled
);
  import scg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_io_wr;
    host_req.wr && host_req.addr == SCG_OFF_IO_RESET;
  endsequence
  sequence s_p0_rd;
    host_req.rd && host_req.addr == SCG_OFF_P0_DATA && io_enabled;
  endsequence
  chk_read_answer: assert property (host_req.rd |=> host_rvalid)
    else $error("read not answered");
  chk_rvalid_cause: assert property (host_rvalid |-> $past(host_req.rd))
    else $error("answer without read");
  chk_io_bit_write: assert property (s_io_wr |=> io_enabled == $past(host_req.wdata[0]))
    else $error("enable bit not stored");
  chk_io_bit_hold: assert property (!(host_req.wr && host_req.addr == SCG_OFF_IO_RESET)
    |=> $stable(io_enabled)) else $error("enable bit moved");
  chk_uart0_gate: assert property (uart0_req.wr == (host_req.wr && io_enabled
    && host_req.addr == SCG_OFF_P0_DATA)) else $error("first port strobe wrong");
  chk_uart1_gate: assert property (uart1_req.rd == (host_req.rd && io_enabled
    && host_req.addr == SCG_OFF_P1_DATA)) else $error("second port strobe wrong");
  chk_uart_rdata: assert property (s_p0_rd |=> host_rdata == $past(uart0_rdata))
    else $error("port data not returned");
  chk_speed_select: assert property (host_req.wr && host_req.addr == SCG_OFF_P0_SPEED
    |=> uart0_speed_high == $past(host_req.wdata[1])) else $error("speed not stored");
  chk_irq_disabled: assert property (!io_enabled |=> host_irq_b)
    else $error("interrupt while disabled");
  chk_oe_disabled: assert property (!io_enabled [*2] |-> aux_pin_oe_b == 8'hFF)
    else $error("pin driven while disabled");
endmodule : scg_glue_regs_checker

bind scg_glue_regs scg_glue_regs_checker u_chk (.clk, .rst_b, .host_req, .host_rdata,
  .host_rvalid, .host_irq_b, .aux_pin_oe_b, .uart0_req, .uart0_rdata, .uart1_req,
  .uart0_speed_high, .io_enabled);

// ### dv/scg_glue_regs_tb.sv
`timescale 1ns/10ps
module scg_glue_regs_tb;
  import scg_pkg::*;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  scg_host_req_type host_req = '0;
  scg_uart_req_type uart0_req, uart1_req;
  logic [7:0]       host_rdata, aux_pin_out, aux_pin_oe_b, uart0_rdata, uart1_rdata;
  logic [7:0]       aux_pin_in = 8'hA0;
  logic             host_rvalid, host_irq_b, uart0_irq, uart1_irq, io_enabled;
  logic             uart0_speed_high, uart1_speed_high;
  logic [7:0]       host_rdata_alt;
  logic             host_irq_b_alt;
  logic             irq_set0 = 1'b0;
  logic             irq_set1 = 1'b0;
  int               failures = 0;
  int               check_count = 0;
  always #2.5 clk = ~clk;
  scg_glue_regs DUT (.clk, .rst_b, .host_req, .host_rdata, .host_rvalid, .host_irq_b,
    .aux_pin_in, .aux_pin_out, .aux_pin_oe_b, .uart0_req, .uart0_rdata, .uart0_irq,
    .uart0_speed_high, .uart1_req, .uart1_rdata, .uart1_irq, .uart1_speed_high, .io_enabled);
  // Alternate variant shares the host bus; only its status and interrupt are watched
  scg_glue_regs #(.ALT_VARIANT(1'b1)) DUT_ALT (.clk, .rst_b, .host_req,
    .host_rdata(host_rdata_alt), .host_rvalid(), .host_irq_b(host_irq_b_alt), .aux_pin_in,
    .aux_pin_out(), .aux_pin_oe_b(), .uart0_req(), .uart0_rdata, .uart0_irq,
    .uart0_speed_high(), .uart1_req(), .uart1_rdata, .uart1_irq, .uart1_speed_high(),
    .io_enabled());
  scg_uart_model u_uart0 (.clk, .req(uart0_req), .irq_set(irq_set0), .rdata(uart0_rdata),
    .irq(uart0_irq));
  scg_uart_model u_uart1 (.clk, .req(uart1_req), .irq_set(irq_set1), .rdata(uart1_rdata),
    .irq(uart1_irq));
  //--------------------------------------------------------------------
  // Access tasks
  //--------------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    host_req <= '{1'b1, 1'b0, addr, data};
    @(posedge clk);
    host_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
    @(posedge clk);
    host_req <= '{1'b0, 1'b1, addr, 8'h00};
    @(posedge clk);
    host_req <= '0;
    #1;
    check("rvalid", 8'h01, {7'h0, host_rvalid});
    check(name, exp, host_rdata);
  endtask : rd
  // Lands just past an edge so registered outputs have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic finish_test;
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  initial begin
    #20000;
    failures++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    step(0);
    check("io_enabled", 8'h00, {7'h0, io_enabled});
    check("oe_b", 8'hFF, aux_pin_oe_b);
    check("irq_b", 8'h01, {7'h0, host_irq_b});
    check("speed", 8'h00, {6'h0, uart1_speed_high, uart0_speed_high});
    rd(SCG_OFF_AUX_DIR, 8'h00, "wo read");
    rd(8'h01, 8'h00, "unmapped");
    wr(SCG_OFF_AUX_DIR, 8'h80);
    wr(SCG_OFF_AUX_DATA, 8'h80);
    step(1);
    check("oe_b off", 8'hFF, aux_pin_oe_b);
    wr(SCG_OFF_IO_RESET, 8'h01);
    step(1);
    check("oe_b", 8'h7F, aux_pin_oe_b);
    check("aux out", 8'h80, aux_pin_out);
    wr(SCG_OFF_P0_DATA, 8'h5A);
    wr(SCG_OFF_P1_DATA, 8'hA5);
    wr(SCG_OFF_IO_RESET, 8'h00);
    wr(SCG_OFF_P0_DATA, 8'h33);
    rd(SCG_OFF_P0_DATA, 8'h00, "p0 off");
    wr(SCG_OFF_IO_RESET, 8'h01);
    rd(SCG_OFF_P0_DATA, 8'h5A, "p0");
    rd(SCG_OFF_P1_DATA, 8'hA5, "p1");
    wr(SCG_OFF_P0_SPEED, 8'h02);
    wr(SCG_OFF_P1_SPEED, 8'hFD);
    step(0);
    check("speed", 8'h01, {6'h0, uart1_speed_high, uart0_speed_high});
    rd(SCG_OFF_AUX_STAT, 8'hA3, "stat inv");
    check("stat inv alt", 8'hAC, host_rdata_alt);
    wr(SCG_OFF_IRQ_POL, 8'h03);
    rd(SCG_OFF_AUX_STAT, 8'hA0, "stat pass");
    check("stat pass alt", 8'hAC, host_rdata_alt);
    @(posedge clk);
    irq_set0 <= 1'b1;
    wr(SCG_OFF_IRQ_EN, 8'h0C);
    step(1);
    check("irq_b alt", 8'h01, {7'h0, host_irq_b});
    check("irq_b alt var", 8'h00, {7'h0, host_irq_b_alt});
    rd(SCG_OFF_AUX_STAT, 8'hA1, "stat ch0");
    check("stat ch0 alt", 8'hA8, host_rdata_alt);
    wr(SCG_OFF_IRQ_EN, 8'h02);
    step(1);
    check("irq_b ch1", 8'h01, {7'h0, host_irq_b});
    check("irq_b ch1 alt", 8'h01, {7'h0, host_irq_b_alt});
    wr(SCG_OFF_IRQ_EN, 8'h01);
    step(1);
    check("irq_b on", 8'h00, {7'h0, host_irq_b});
    step(3);
    check("irq_b held", 8'h00, {7'h0, host_irq_b});
    wr(SCG_OFF_IO_RESET, 8'h00);
    step(1);
    check("irq_b off", 8'h01, {7'h0, host_irq_b});
    check("oe_b end", 8'hFF, aux_pin_oe_b);
    finish_test;
  end
endmodule : scg_glue_regs_tb
